// >>> spectral_sensor_control_regs.sv
// Purpose: Control and status register bank of a three-device spectral sensor chipset
// Assumes: Byte register port from the serial slave; chip select held elsewhere
// Notes:   Reads answer one cycle after the strobe
// How it works
// - Writing control bit 7 soft-resets; reading it returns gain error.
// - Gain field picks 1x, 3.7x, 16x or 64x; resets to code 01.
// - Modes 00 and 01 each convert a distinct four-channel set.
// - Mode 10, the reset value, converts all six channels continuously.
// - Mode 11 converts all six channels once, then stops.
// - Each step lasts 2.78ms; setting v gives v+1 steps, 1024 counts each.
// - Count ceiling saturates at 65535 from 64 steps upward.
// - Firmware selector 1, 2 or 3 returns major, patch or build byte.
// - Temperature reads as signed degrees from -127 to 127.
// - Unavailable temperature reads as -128.
// - Temperature comes from the device named by the chip select.
// - Illumination current limit codes 12.5, 25, 50, 100mA per selected device.
// - Indicator current limit codes 1, 2, 4, 8mA; resets to 01.
// - Illumination drive enable of the selected device; resets to zero.
// - Indicator drive enable of the selected device; resets to zero.
// - Read-only lamp fault bit set on a status read error.
// - First raw count: high byte at lower address, from selected device.
`timescale 1ns/1ps
`include "spectral_defs.svh"
module spectral_sensor_control_regs
  import spectral_pkg::*;
#(
  parameter int          STEP_CYCLES = `STEP_CYCLES,
  parameter logic [7:0]  HW_TYPE     = 8'h5A,  // Arbitrary value
  parameter logic [7:0]  HW_REV      = 8'h01,  // Arbitrary value
  parameter logic [7:0]  FW_MAJOR    = 8'h01,
  parameter logic [7:0]  FW_PATCH    = 8'h00,
  parameter logic [7:0]  FW_BUILD    = 8'h00
) (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire reg_req_s        reg_req,
  output logic      [7:0]      reg_rdata,
  output logic                 reg_rvalid,
  input  wire logic [1:0]      sensor_chip_select,
  input  wire logic            gain_err,
  input  wire logic [2:0][7:0] temp_c,
  input  wire logic [2:0]      temp_ok,
  input  wire logic [2:0]      status_err,
  input  wire logic [2:0]      photon_pin,
  output lamp_s     [2:0]      lamp_drive,
  output logic      [1:0]      gain_code,
  output logic      [5:0]      channel_mask,
  output logic                 integrating,
  output logic                 soft_reset_pulse,
  output logic                 int_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  ctl_s             q;
  ctl_s             d;
  logic [2:0]       photon_lvl;
  logic [2:0][15:0] count;
  logic [8:0]       steps;
  logic [15:0]      max_cnt;
  logic             sel_ok;
  logic [1:0]       sel;
  logic             wr_ctrl;
  logic             wr_expo;
  logic             restart;
  logic             conv_done;
  lamp_s            lamp_rst;

  if (STEP_CYCLES < 1 || STEP_CYCLES > 24'hFF_FFFF) begin : g_chk
    $error("spectral_sensor_control_regs: STEP_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Photon inputs arrive from the sensor dies on pins

  level_sync3 #(
    .W (3)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (photon_pin),
    .dout    (photon_lvl)
  );

  // One integrator per device; the clearing cycle counts too, so a window is whole cycles
  for (genvar i = 0; i < 3; i++) begin : g_integ
    exposure_integrator u_integ (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clr     (q.state == S_IDLE),
      .en      (q.state != S_HOLD),
      .level   (photon_lvl[i]),
      .max_cnt (max_cnt),
      .count   (count[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exposure length to step count and count ceiling

  assign steps   = {1'b0, q.expo} + 9'h001;
  assign max_cnt = (steps >= `SAT_STEPS) ? `COUNT_CEIL
                 : 16'({steps[5:0], 10'h000}) - 16'h0001;

  // Chip select beyond the third device addresses nothing
  assign sel    = sensor_chip_select;
  assign sel_ok = (sensor_chip_select != 2'h3);

  assign wr_ctrl = reg_req.wr && (reg_req.addr == `OFS_CTRL);
  assign wr_expo = reg_req.wr && (reg_req.addr == `OFS_EXPO);
  // Any change of measurement settings starts a fresh conversion
  assign restart = wr_ctrl || wr_expo;

  assign conv_done = (q.state == S_INTEG) && (q.tick == 24'(STEP_CYCLES - 1))
                   && (q.step_left == 9'h001);

  always_comb begin
    lamp_rst                         = '0;
    lamp_rst.illum_current_limit     = `ILIM_RST;
    lamp_rst.indicator_current_limit = `NLIM_RST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d          = q;
    d.rvalid   = 1'b0;
    d.soft_rst = 1'b0;

    // Measurement sequencer
    case (q.state)
      S_IDLE: begin
        d.tick      = 24'h00_0000;
        d.step_left = steps;
        d.state     = S_INTEG;
      end
      S_INTEG: begin
        if (q.tick == 24'(STEP_CYCLES - 1)) begin
          d.tick      = 24'h00_0000;
          d.step_left = q.step_left - 9'h001;
          if (q.step_left == 9'h001) begin
            d.raw = count;
            // One-shot parks after one pass; other modes repeat
            d.state = (q.mode == `MODE_ONESHOT) ? S_HOLD : S_IDLE;
          end
        end else begin
          d.tick = q.tick + 24'h00_0001;
        end
      end
      S_HOLD: begin
        d.state = S_HOLD;
      end
      default: begin
        d.state = S_IDLE;
      end
    endcase

    // Read side effects clear flags; hardware set below wins
    if (reg_req.rd && reg_req.addr == `OFS_RAW_HI) begin
      d.data_rdy = 1'b0;
      d.low_snap = sel_ok ? q.raw[sel][7:0] : 8'h00;
    end
    if (reg_req.rd && reg_req.addr == `OFS_LAMP && sel_ok) begin
      d.fault[sel] = 1'b0;
    end

    // Register writes
    if (reg_req.wr) begin
      if (reg_req.addr == `OFS_FW_HI || reg_req.addr == `OFS_FW_LO) begin
        d.fw_sel = reg_req.wdata;
      end else if (reg_req.addr == `OFS_CTRL) begin
        d.int_en = reg_req.wdata[`CTRL_INT_BIT];
        d.gain   = reg_req.wdata[`CTRL_GAIN_LSB +: 2];
        d.mode   = reg_req.wdata[`CTRL_MODE_LSB +: 2];
      end else if (reg_req.addr == `OFS_EXPO) begin
        d.expo = reg_req.wdata;
      end else if (reg_req.addr == `OFS_LAMP && sel_ok) begin
        d.lamp[sel].illum_current_limit     = reg_req.wdata[`LAMP_ILIM_LSB +: 2];
        d.lamp[sel].illum_drive_on          = reg_req.wdata[`LAMP_ION_BIT];
        d.lamp[sel].indicator_current_limit = reg_req.wdata[`LAMP_NLIM_LSB +: 2];
        d.lamp[sel].indicator_drive_on      = reg_req.wdata[`LAMP_NON_BIT];
      end
    end

    if (restart) begin
      d.state = S_IDLE;
    end

    // Soft reset restarts measurement and drops any pending result
    if (wr_ctrl && reg_req.wdata[`CTRL_SOFT_RESET_GAIN_ERR_BIT]) begin
      d.soft_rst = 1'b1;
      d.data_rdy = 1'b0;
    end

    // Factory restore overrides every setting of the same write
    if (wr_ctrl && reg_req.wdata[`CTRL_FACTORY_RESTORE_BIT]) begin
      d.fw_sel = `FW_SEL_RST;
      d.int_en = 1'b0;
      d.gain   = `GAIN_RST;
      d.mode   = `MODE_RST;
      d.expo   = `EXPO_RST;
      for (int i = 0; i < 3; i++) begin
        d.lamp[i] = lamp_rst;
      end
    end

    // Hardware set wins over read clear; a soft reset still drops a result of its own cycle
    if (conv_done && !d.soft_rst) begin
      d.data_rdy = 1'b1;
    end
    for (int i = 0; i < 3; i++) begin
      if (status_err[i]) begin
        d.fault[i] = 1'b1;
      end
    end

    // Read data, answered one cycle after the strobe
    if (reg_req.rd) begin
      d.rvalid = 1'b1;
      if (reg_req.addr == `OFS_HW_HI) begin
        d.rdata = HW_TYPE;
      end else if (reg_req.addr == `OFS_HW_LO) begin
        d.rdata = HW_REV;
      end else if (reg_req.addr == `OFS_FW_HI) begin
        if (q.fw_sel == `FW_SEL_MAJOR) begin
          d.rdata = FW_MAJOR;
        end else if (q.fw_sel == `FW_SEL_PATCH) begin
          d.rdata = FW_PATCH;
        end else if (q.fw_sel == `FW_SEL_BUILD) begin
          d.rdata = FW_BUILD;
        end else begin
          d.rdata = 8'h00;
        end
      end else if (reg_req.addr == `OFS_FW_LO) begin
        d.rdata = q.fw_sel;
      end else if (reg_req.addr == `OFS_CTRL) begin
        d.rdata = {gain_err, q.int_en, q.gain, q.mode, q.data_rdy, 1'b0};
      end else if (reg_req.addr == `OFS_EXPO) begin
        d.rdata = q.expo;
      end else if (reg_req.addr == `OFS_TEMP) begin
        // Out-of-range select or a missing reading gives the error marker
        if (sel_ok && temp_ok[sel] && temp_c[sel] != `TEMP_ERR) begin
          d.rdata = temp_c[sel];
        end else begin
          d.rdata = `TEMP_ERR;
        end
      end else if (reg_req.addr == `OFS_LAMP) begin
        d.rdata = sel_ok ? {q.fault[sel], 1'b0, q.lamp[sel].illum_current_limit,
                            q.lamp[sel].illum_drive_on, q.lamp[sel].indicator_current_limit,
                            q.lamp[sel].indicator_drive_on} : 8'h00;
      end else if (reg_req.addr == `OFS_RAW_HI) begin
        d.rdata = sel_ok ? q.raw[sel][15:8] : 8'h00;
      end else if (reg_req.addr == `OFS_RAW_LO) begin
        d.rdata = q.low_snap;
      end else begin
        d.rdata = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q           <= '0;
      q.gain      <= `GAIN_RST;
      q.mode      <= `MODE_RST;
      q.expo      <= `EXPO_RST;
      q.fw_sel    <= `FW_SEL_RST;
      q.state     <= S_IDLE;
      for (int i = 0; i < 3; i++) begin
        q.lamp[i].illum_current_limit     <= `ILIM_RST;
        q.lamp[i].indicator_current_limit <= `NLIM_RST;
      end
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata        = q.rdata;
  assign reg_rvalid       = q.rvalid;
  assign lamp_drive       = q.lamp;
  assign gain_code        = q.gain;
  assign integrating      = (q.state == S_INTEG);
  assign soft_reset_pulse = q.soft_rst;
  assign int_pin          = q.int_en & q.data_rdy;

  // Photodiode set for the measurement mode
  always_comb begin
    if (q.mode == `MODE_SET_A) begin
      channel_mask = `MASK_SET_A;
    end else if (q.mode == `MODE_SET_B) begin
      channel_mask = `MASK_SET_B;
    end else begin
      channel_mask = `MASK_ALL;
    end
  end

endmodule

// >>> spectral_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the sensor register bank
// Assumes: Byte-wide register port, 40 MHz clock
// Notes:   Definitions only
`ifndef SPECTRAL_DEFS_SVH
`define SPECTRAL_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define OFS_HW_HI      8'h00
`define OFS_HW_LO      8'h01
`define OFS_FW_HI      8'h02
`define OFS_FW_LO      8'h03
`define OFS_CTRL       8'h04
`define OFS_EXPO       8'h05
`define OFS_TEMP       8'h06
`define OFS_LAMP       8'h07
`define OFS_RAW_HI     8'h08
`define OFS_RAW_LO     8'h09

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define CTRL_SOFT_RESET_GAIN_ERR_BIT  7
`define CTRL_INT_BIT   6
`define CTRL_GAIN_LSB  4
`define CTRL_MODE_LSB  2
`define CTRL_RDY_BIT   1
`define CTRL_FACTORY_RESTORE_BIT  0
`define LAMP_ERR_BIT   7
`define LAMP_ILIM_LSB  4
`define LAMP_ION_BIT   3
`define LAMP_NLIM_LSB  1
`define LAMP_NON_BIT   0

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define GAIN_RST       2'h1
`define MODE_RST       2'h2
`define EXPO_RST       8'h14
`define ILIM_RST       2'h0
`define NLIM_RST       2'h1
`define FW_SEL_RST     8'h00

////////////////////////////////////////////////////////////////////////////////
// Codes
`define MODE_SET_A     2'h0
`define MODE_SET_B     2'h1
`define MODE_ALL       2'h2
`define MODE_ONESHOT   2'h3
`define MASK_SET_A     6'h0F
`define MASK_SET_B     6'h3C
`define MASK_ALL       6'h3F
`define FW_SEL_MAJOR   8'h01
`define FW_SEL_PATCH   8'h02
`define FW_SEL_BUILD   8'h03
`define TEMP_ERR       8'h80

////////////////////////////////////////////////////////////////////////////////
// Timing
`define CLK_PERIOD_NS  25
`define EXPO_STEP_NS   2780000
`define STEP_CYCLES    (`EXPO_STEP_NS / `CLK_PERIOD_NS)
`define SAT_STEPS      9'h040
`define COUNT_CEIL     16'hFFFF

`endif

// >>> spectral_pkg.sv
// Purpose: Types shared by the sensor register bank, its checks, host model and bench
// Assumes: Three sensor devices in the chipset
// Notes:   Constants live in spectral_defs.svh
package spectral_pkg;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_INTEG = 3'b010,
    S_HOLD  = 3'b100
  } seq_e;

  // One register access from the serial slave
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  // Lamp drive settings of one sensor device
  typedef struct packed {
    logic [1:0] illum_current_limit;
    logic       illum_drive_on;
    logic [1:0] indicator_current_limit;
    logic       indicator_drive_on;
  } lamp_s;

  // Whole state of the register bank
  typedef struct packed {
    logic [7:0]       fw_sel;
    logic             int_en;
    logic [1:0]       gain;
    logic [1:0]       mode;
    logic             data_rdy;
    logic [7:0]       expo;
    lamp_s [2:0]      lamp;
    logic [2:0]       fault;
    seq_e             state;
    logic [23:0]      tick;
    logic [8:0]       step_left;
    logic [2:0][15:0] raw;
    logic [7:0]       low_snap;
    logic [7:0]       rdata;
    logic             rvalid;
    logic             soft_rst;
  } ctl_s;

endpackage

// >>> level_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
module level_sync3 #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_s;

  sync_s q;
  sync_s d;

  if (W < 1) begin : g_chk
    $error("level_sync3: W must be at least 1");
  end

  // Per-bit filter; stage one feeds only stage two
  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.lvl;

endmodule

// >>> exposure_integrator.sv
// Purpose: Counts photon pulses of one sensor device during integration
// Assumes: Level input already synchronised
// Notes:   Count saturates at the ceiling given by the exposure setting
`timescale 1ns/1ps
module exposure_integrator (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic        level,
  input  wire logic [15:0] max_cnt,
  output logic      [15:0] count
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        prev;
  } integ_s;

  integ_s q;
  integ_s d;

  // Rising edges count; held at the ceiling so long exposures do not wrap
  always_comb begin
    d      = q;
    d.prev = level;
    if (clr) begin
      // An edge on the clearing cycle opens the window, so it spans whole cycles
      d.cnt = {15'h0000, en && level && !q.prev};
    end else if (en && level && !q.prev && (q.cnt < max_cnt)) begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count = q.cnt;

endmodule

// >>> spectral_regs_properties.sv
// Purpose: Port-level checks of the sensor register bank
// Assumes: One clock domain, sys_rst asynchronous and active high
// Notes:   Attached by the bind at the foot of this file
`timescale 1ns/1ps
module spectral_regs_properties
  import spectral_pkg::*;
(
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire reg_req_s        reg_req,
  input wire logic [7:0]      reg_rdata,
  input wire logic            reg_rvalid,
  input wire logic [1:0]      sensor_chip_select,
  input wire logic [2:0][7:0] temp_c,
  input wire logic [2:0]      temp_ok,
  input wire lamp_s [2:0]     lamp_drive,
  input wire logic [1:0]      gain_code,
  input wire logic [5:0]      channel_mask,
  input wire logic            integrating,
  input wire logic            soft_reset_pulse,
  input wire logic            int_pin
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////
  // Channel set of each measurement mode
  function automatic logic [5:0] mask_of(input logic [1:0] m);
    return (m == 2'h0) ? 6'h0F : ((m == 2'h1) ? 6'h3C : 6'h3F);
  endfunction

  // Access steps; a control write with bit 0 set is a factory restore
  sequence s_ctrl_wr;
    reg_req.wr && reg_req.addr == 8'h04;
  endsequence
  sequence s_soft_reset_gain_err_wr;
    s_ctrl_wr ##0 reg_req.wdata[7];
  endsequence
  sequence s_temp_rd;
    reg_req.rd && reg_req.addr == 8'h06;
  endsequence

  ////////////////////////////////////////
  a_read_answer: assert property (reg_rvalid == $past(reg_req.rd))
    else $error("read answer not one cycle after strobe");
  a_soft_reset: assert property (s_soft_reset_gain_err_wr |=> soft_reset_pulse ##1 integrating)
    else $error("soft reset pulse or restart missing");
  a_pulse_cause: assert property (soft_reset_pulse |->
      $past(reg_req.wr && reg_req.addr == 8'h04 && reg_req.wdata[7]))
    else $error("soft reset pulse without write");
  a_gain_store: assert property (s_ctrl_wr ##0 !reg_req.wdata[0] |=>
      gain_code == $past(reg_req.wdata[5:4]))
    else $error("gain field not stored");
  a_mode_mask: assert property (s_ctrl_wr ##0 !reg_req.wdata[0] |=>
      channel_mask == mask_of($past(reg_req.wdata[3:2])))
    else $error("channel set wrong for mode");
  a_factory_dflt: assert property (s_ctrl_wr ##0 reg_req.wdata[0] |=>
      gain_code == 2'h1 && channel_mask == 6'h3F)
    else $error("factory restore left settings");
  a_temp_value: assert property (s_temp_rd ##0 (
      sensor_chip_select != 2'h3 && temp_ok[sensor_chip_select] &&
      temp_c[sensor_chip_select] != 8'h80) |=> reg_rdata == $past(temp_c[sensor_chip_select]))
    else $error("temperature of selected device wrong");
  a_temp_error: assert property (s_temp_rd ##0 (
      sensor_chip_select == 2'h3 || !temp_ok[sensor_chip_select]) |=> reg_rdata == 8'h80)
    else $error("temperature error marker missing");
  a_lamp_write: assert property (
      reg_req.wr && reg_req.addr == 8'h07 && sensor_chip_select != 2'h3 |=>
      lamp_drive[$past(sensor_chip_select)] == $past(reg_req.wdata[5:0]))
    else $error("lamp settings not applied");
  a_int_quiet: assert property (soft_reset_pulse |-> !int_pin)
    else $error("interrupt high during soft reset");
endmodule

bind spectral_sensor_control_regs spectral_regs_properties i_props (.clk(clk), .sys_rst(sys_rst),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .sensor_chip_select(sensor_chip_select), .temp_c(temp_c), .temp_ok(temp_ok),
  .lamp_drive(lamp_drive), .gain_code(gain_code), .channel_mask(channel_mask),
  .integrating(integrating), .soft_reset_pulse(soft_reset_pulse), .int_pin(int_pin));

// >>> host_port_model.sv
// Purpose: Host controller model on the byte register port
// Assumes: One access at a time, read answer one cycle after the strobe
// Notes:   Released lines show the inverse of the last value, never a held copy
`timescale 1ns/1ps
module host_port_model
  import spectral_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reg_rvalid,
  input  wire logic [7:0] reg_rdata,
  output reg_req_s        reg_req
);
  initial begin
    reg_req = '0;
  end

  // Write: one strobe edge, then scramble address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge clk);
    reg_req.wr <= 1'b0;
    reg_req.addr <= ~a;
    reg_req.wdata <= ~d;
  endtask

  // Read: bounded wait so a missing answer shows as unknown data
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge clk);
    reg_req.rd <= 1'b0;
    reg_req.addr <= ~a;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (reg_rvalid !== 1'b1 && n < 4);
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule

// >>> spectral_sensor_control_regs_tb.sv
// Purpose: Self-checking bench of the sensor register bank
// Assumes: Short integration step so conversions finish quickly
// Notes:   Photon pins toggle every second cycle so the pin filter passes them
`timescale 1ns/1ps
module spectral_sensor_control_regs_tb
  import spectral_pkg::*;
;
  localparam int STEP = 16;
  logic            clk;
  logic            sys_rst;
  logic            gain_err;
  logic [1:0]      sensor_chip_select;
  logic [2:0][7:0] temp_c;
  logic [2:0]      temp_ok;
  logic [2:0]      status_err;
  logic [2:0]      photon_pin;
  logic [7:0]      reg_rdata;
  logic [7:0]      rd_v;
  logic [5:0]      lamp_v;
  logic            reg_rvalid;
  logic            integrating;
  logic            soft_reset_pulse;
  logic            int_pin;
  logic [1:0]      gain_code;
  logic [5:0]      channel_mask;
  lamp_s [2:0]     lamp_drive;
  reg_req_s        reg_req;
  int              err_count;
  int              cmp_count;
  int              cycles;
  int              n;

  spectral_sensor_control_regs #(.STEP_CYCLES(STEP), .FW_MAJOR(8'h11), .FW_PATCH(8'h22),
    .FW_BUILD(8'h33)) i_spectral_sensor_control_regs (.clk(clk), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sensor_chip_select(sensor_chip_select), .gain_err(gain_err), .temp_c(temp_c),
    .temp_ok(temp_ok), .status_err(status_err), .photon_pin(photon_pin),
    .lamp_drive(lamp_drive), .gain_code(gain_code), .channel_mask(channel_mask),
    .integrating(integrating), .soft_reset_pulse(soft_reset_pulse), .int_pin(int_pin));
  host_port_model host (.clk(clk), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
    .reg_req(reg_req));

  ////////////////////////////////////////
  // Clock, photon stimulus and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    // Levels held two cycles; a pin toggling every cycle never passes the filter
    if (cycles[0])
      photon_pin <= ~photon_pin;
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    host.rd(a, rd_v);
    check($sformatf("reg %h", a), rd_v & m, e);
  endtask
  task automatic conclude();
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [5:0] mask_exp(input logic [1:0] m);
    return (m == 2'h0) ? 6'h0F : ((m == 2'h1) ? 6'h3C : 6'h3F);
  endfunction
  // Value 0x80 at the input is itself an error marker
  function automatic logic [7:0] temp_exp(input logic [1:0] s);
    if (s == 2'h3 || !temp_ok[s] || temp_c[s] == 8'h80)
      return 8'h80;
    return temp_c[s];
  endfunction
  // Ceiling grows by 1024 a step; one counted edge per four cycles
  function automatic logic [15:0] cnt_exp(input int v);
    int c;
    c = (v + 1) * STEP / 4;
    return 16'((c > (v + 1) * 1024 - 1) ? (v + 1) * 1024 - 1 : c);
  endfunction

  ////////////////////////////////////////
  initial begin
    {sys_rst, gain_err, sensor_chip_select, temp_c, temp_ok, status_err} = {1'b1, 33'h0};
    photon_pin = 3'h0;
    err_count = 0;
    cmp_count = 0;
    cycles = 0;
    void'($urandom(32'h0b35_d5fa));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rc(8'h04, 8'h7F, 8'h18);
    rc(8'h07, 8'hFF, 8'h02);
    rc(8'h0A, 8'hFF, 8'h00);
    for (int i = 1; i < 4; i++) begin
      host.wr(8'h03, 8'(i));
      rc(8'h02, 8'hFF, 8'(i * 8'h11));
    end
    // Every gain and mode code, gain error drawn at random
    for (int i = 0; i < 16; i++) begin
      gain_err <= 1'($urandom);
      host.wr(8'h04, {2'b00, 4'(i), 2'b00});
      #1;
      check("gain", {6'h0, gain_code}, 8'(i >> 2));
      check("mask", {2'h0, channel_mask}, 8'(mask_exp(2'(i))));
      rc(8'h04, 8'hFD, {gain_err, 7'(4 * i)});
    end
    // Temperature per device; writes to it are ignored
    host.wr(8'h06, 8'h55);
    for (int i = 0; i < 8; i++) begin
      temp_c <= (i == 0) ? 24'h81_7F80 : 24'($urandom);
      temp_ok <= (i == 0) ? 3'h7 : 3'($urandom);
      sensor_chip_select <= 2'(i);
      host.rd(8'h06, rd_v);
      check("temp", rd_v, temp_exp(sensor_chip_select));
    end
    // Lamp settings per device; no device selected reads zero
    for (int i = 0; i < 4; i++) begin
      sensor_chip_select <= 2'(i);
      lamp_v = 6'($urandom);
      host.wr(8'h07, {2'b00, lamp_v});
      #1;
      if (i < 3)
        check("lamp", 8'(lamp_drive[i]), 8'(lamp_v));
      rc(8'h07, 8'h7F, (i < 3) ? 8'(lamp_v) : 8'h00);
    end
    sensor_chip_select <= 2'h1;
    status_err <= 3'b010;
    @(posedge clk);
    status_err <= 3'b000;
    rc(8'h07, 8'h80, 8'h80);
    rc(8'h07, 8'h80, 8'h00);
    // One-shot conversions with the interrupt enabled
    sensor_chip_select <= 2'h0;
    for (int v = 0; v < 2; v++) begin
      host.wr(8'h05, 8'(v));
      host.rd(8'h08, rd_v);
      host.wr(8'h04, 8'h4C);
      n = 0;
      while (int_pin !== 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      repeat (3 * STEP) @(posedge clk);
      check("integrating", {7'h0, integrating}, 8'h00);
      check("int", {7'h0, int_pin}, 8'h01);
      rc(8'h08, 8'hFF, 8'(cnt_exp(v) >> 8));
      rc(8'h09, 8'hFF, 8'(cnt_exp(v)));
      check("int", {7'h0, int_pin}, 8'h00);
    end
    // Factory restore, then a soft reset over a finished conversion
    host.wr(8'h05, 8'h07);
    host.wr(8'h04, 8'h01);
    rc(8'h04, 8'hFD, {gain_err, 7'h18});
    rc(8'h05, 8'hFF, 8'h14);
    host.wr(8'h05, 8'h00);
    repeat (20) @(posedge clk);
    host.wr(8'h04, 8'hC8);
    #1;
    check("soft", {7'h0, soft_reset_pulse}, 8'h01);
    check("int", {7'h0, int_pin}, 8'h00);
    repeat (3) @(negedge clk);
    check("restart", {7'h0, integrating}, 8'h01);
    conclude();
  end
endmodule
